// >>> hw/bbrs_pkg.sv
// constants and types shared by both ends of the segment link
package bbrs_pkg;
    // addressing of the segment stream
    localparam logic [31:0] BBRS_MCAST_IP   = 32'hEF003330;
    localparam logic [15:0] BBRS_PORT_BASE  = 16'h7530;
    // fixed header field values
    localparam logic [1:0]  BBRS_RTP_VER    = 2'h2;
    localparam logic [6:0]  BBRS_PT         = 7'h4E;
    localparam logic [3:0]  BBRS_CC         = 4'h0;
    localparam logic        BBRS_PAD        = 1'b0;
    // timestamp field positions
    localparam int          BBRS_SEC_W      = 22;
    localparam int          BBRS_NS_HI      = 29;
    localparam int          BBRS_NS_LO      = 20;
    // register byte offsets
    localparam logic [11:0] BBRS_OFS_CTRL   = 12'h000;
    localparam logic [11:0] BBRS_OFS_MAXPAY = 12'h004;
    localparam logic [11:0] BBRS_OFS_CHOFS  = 12'h008;
    localparam logic [11:0] BBRS_OFS_EXTHDR = 12'h00C;
    localparam logic [11:0] BBRS_OFS_STATUS = 12'h010;
    localparam logic [11:0] BBRS_OFS_ISTAT  = 12'h014;
    localparam logic [11:0] BBRS_OFS_IMASK  = 12'h018;
    // control fields and reset values
    localparam int          BBRS_CTRL_EN    = 0;
    localparam int          BBRS_CTRL_SEG   = 1;
    localparam logic [1:0]  BBRS_CTRL_RST   = 2'h3;
    localparam logic [15:0] BBRS_MAXPAY_RST = 16'h05B4;
    localparam logic [15:0] BBRS_CHOFS_RST  = 16'h0000;
    localparam logic [31:0] BBRS_EXTHDR_RST = 32'h00000000;
    localparam logic [1:0]  BBRS_IMASK_RST  = 2'h0;
    // interrupt status bits
    localparam int          BBRS_INT_SET    = 0;
    localparam int          BBRS_INT_PKT    = 1;
    // state types
    typedef enum logic [0:0] {SEG_IDLE, SEG_BODY} bbrs_seg_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_COLLECT, RX_PLAY} bbrs_rx_state_e;
endpackage

// >>> hw/bbrs_link_if.sv
// segment link between segmenter and consumer, one byte per beat
`timescale 1ns/1ps
interface bbrs_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic        valid;
    logic        ready;
    logic        sop;
    logic        eop;
    logic [7:0]  data;
    logic [1:0]  ver;
    logic        pad;
    logic        ext;
    logic [3:0]  cc;
    logic        marker;
    logic [6:0]  pt;
    logic [15:0] seq;
    logic [31:0] ts;
    logic [31:0] ssrc;
    logic [31:0] ext_word;
    logic [31:0] dst_ip;
    logic [15:0] dst_port;

    modport seg (output valid, sop, eop, data, ver, pad, ext, cc, marker,
                 pt, seq, ts, ssrc, ext_word, dst_ip, dst_port,
                 input ready);
    modport rx  (input valid, sop, eop, data, ver, pad, ext, cc, marker,
                 pt, seq, ts, ssrc, ext_word, dst_ip, dst_port,
                 output ready);
endinterface

// >>> hw/bbrs_segmenter.sv
// baseband packet segmenter with apb control and interrupt
// Summary of operation
// [RULE_01] timestamp: sec[21:0], nsec[29:20]
// [RULE_02] multicast group, port base plus pipe; the code also adds the chofs_ff offset to the port
// [RULE_03] marker only on first packet
// [RULE_04] one timestamp per set
// [RULE_05] first ssrc holds total length
// [RULE_06] continuation ssrc is zero
// [RULE_07] collect until signalled length
// [RULE_08] gap or early marker drops set
// [RULE_09] extension bit marks signed
// [RULE_10] csrc count always zero
// [RULE_11] payload type always 78
// [RULE_12] sequence steps per packet, no padding
// [RULE_13] extension word after ssrc if signed
// [RULE_14] consumer orders by sequence; the consumer does not reorder, a packet out of sequence drops the set
// [RULE_15] split at max payload if enabled
// [RULE_16] any fragment count and size
// [RULE_17] deliver exact length, drop overrun
`timescale 1ns/1ps
module bbrs_segmenter
    import bbrs_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // baseband packet input
    input  wire logic        bb_valid,
    output logic             bb_ready,
    input  wire logic [7:0]  bb_data,
    input  wire logic        bb_last,
    input  wire logic [31:0] bb_len,
    input  wire logic [5:0]  bb_pipe,
    input  wire logic [31:0] bb_sec,
    input  wire logic [31:0] bb_nsec,
    input  wire logic        bb_signed,
    // segment link
    bbrs_link_if.seg         link
);
    bbrs_seg_state_e state_ff;
    logic [1:0]      ctrl_ff;
    logic [15:0]     maxpay_ff;
    logic [15:0]     chofs_ff;
    logic [31:0]     exthdr_ff;
    logic [1:0]      istat_ff;
    logic [1:0]      imask_ff;
    logic [31:0]     prdata_ff;
    logic            slverr_ff;
    logic [15:0]     pay_cnt_ff;
    logic [15:0]     seq_ff;
    logic            out_valid_ff;
    logic            out_sop_ff;
    logic            out_eop_ff;
    logic [7:0]      out_data_ff;
    logic            marker_ff;
    logic            ext_ff;
    logic [15:0]     hseq_ff;
    logic [31:0]     ts_ff;
    logic [31:0]     ssrc_ff;
    logic [31:0]     ext_word_ff;
    logic [15:0]     port_ff;
    logic            take;
    logic            first;
    logic            pkt_start;
    logic            max_hit;
    logic            wr_acc;
    logic            ev_set;
    logic            ev_pkt;
    logic [1:0]      nxt_istat;
    logic [31:0]     rd_mux;
    logic            rd_hit;

    // apb handshake: zero wait states
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = slverr_ff;
    assign wr_acc  = psel && penable && pwrite && !slverr_ff;

    // read decode, sampled in the setup cycle
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            BBRS_OFS_CTRL:   rd_mux = {30'h0, ctrl_ff};
            BBRS_OFS_MAXPAY: rd_mux = {16'h0, maxpay_ff};
            BBRS_OFS_CHOFS:  rd_mux = {16'h0, chofs_ff};
            BBRS_OFS_EXTHDR: rd_mux = exthdr_ff;
            BBRS_OFS_STATUS: rd_mux = {seq_ff, 15'h0, state_ff == SEG_BODY};
            BBRS_OFS_ISTAT:  rd_mux = {30'h0, istat_ff};
            BBRS_OFS_IMASK:  rd_mux = {30'h0, imask_ff};
            default:         rd_hit = 1'b0;
        endcase
    end

    // read data and error flag latched at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            slverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= pwrite ? 32'h0 : rd_mux;
            slverr_ff <= !rd_hit;
        end
    end

    // writable control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= BBRS_CTRL_RST;
            maxpay_ff <= BBRS_MAXPAY_RST;
            chofs_ff  <= BBRS_CHOFS_RST;
            exthdr_ff <= BBRS_EXTHDR_RST;
            imask_ff  <= BBRS_IMASK_RST;
        end else if (wr_acc) begin
            case (paddr)
                BBRS_OFS_CTRL:   ctrl_ff   <= pwdata[1:0];
                BBRS_OFS_MAXPAY: maxpay_ff <= pwdata[15:0];
                BBRS_OFS_CHOFS:  chofs_ff  <= pwdata[15:0];
                BBRS_OFS_EXTHDR: exthdr_ff <= pwdata;
                BBRS_OFS_IMASK:  imask_ff  <= pwdata[1:0];
                default:         ;
            endcase
        end
    end

    // sticky events, write one to clear, set wins
    assign ev_set = take && bb_last;
    assign ev_pkt = link.valid && link.ready && link.eop;
    always_comb begin
        nxt_istat = istat_ff;
        if (wr_acc && paddr == BBRS_OFS_ISTAT) begin
            nxt_istat = istat_ff & ~pwdata[1:0];
        end
        nxt_istat[BBRS_INT_SET] = nxt_istat[BBRS_INT_SET] | ev_set;
        nxt_istat[BBRS_INT_PKT] = nxt_istat[BBRS_INT_PKT] | ev_pkt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_ff <= 2'h0;
        end else begin
            istat_ff <= nxt_istat;
        end
    end

    assign irq = |(istat_ff & imask_ff);

    // take input when the byte slot frees
    assign bb_ready  = ctrl_ff[BBRS_CTRL_EN]
                       && (!out_valid_ff || link.ready);
    assign take      = bb_valid && bb_ready;
    assign first     = state_ff == SEG_IDLE;
    assign pkt_start = first || pay_cnt_ff == 16'h0000;
    // packet boundary at payload limit
    assign max_hit   = ctrl_ff[BBRS_CTRL_SEG]
                       && (pay_cnt_ff + 16'h0001 >= maxpay_ff); // RULE_15

    // set state: body from first byte to last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= SEG_IDLE;
        end else if (take) begin
            case (state_ff)
                SEG_IDLE, SEG_BODY: state_ff <= bb_last ? SEG_IDLE : SEG_BODY;
                default:  state_ff <= SEG_IDLE;
            endcase
        end
    end

    // payload byte count within the current packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pay_cnt_ff <= 16'h0000;
        end else if (take) begin
            pay_cnt_ff <= (bb_last || max_hit) ? 16'h0000
                                               : pay_cnt_ff + 16'h0001;
        end
    end

    // sequence number, one step per packet started
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_ff <= 16'h0000;
        end else if (take && pkt_start) begin
            seq_ff <= seq_ff + 16'h0001; // RULE_12
        end
    end

    // output byte register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_ff <= 1'b0;
            out_sop_ff   <= 1'b0;
            out_eop_ff   <= 1'b0;
            out_data_ff  <= 8'h00;
        end else if (take) begin
            out_valid_ff <= 1'b1;
            out_sop_ff   <= pkt_start;
            out_eop_ff   <= bb_last || max_hit;
            out_data_ff  <= bb_data;
        end else if (link.ready) begin
            out_valid_ff <= 1'b0;
        end
    end

    // header fields, loaded at packet start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            marker_ff   <= 1'b0;
            ext_ff      <= 1'b0;
            hseq_ff     <= 16'h0;
            ts_ff       <= 32'h0;
            ssrc_ff     <= 32'h0;
            ext_word_ff <= 32'h0;
            port_ff     <= 16'h0;
        end else if (take && pkt_start) begin
            marker_ff <= first; // RULE_03
            ssrc_ff   <= first ? bb_len : 32'h0; // RULE_05 RULE_06
            hseq_ff   <= seq_ff; // RULE_12
            if (first) begin
                // set-wide fields
                ts_ff       <= {bb_sec[BBRS_SEC_W-1:0],
                                bb_nsec[BBRS_NS_HI:BBRS_NS_LO]}; // RULE_01 RULE_04
                ext_ff      <= bb_signed; // RULE_09
                ext_word_ff <= bb_signed ? exthdr_ff : 32'h0; // RULE_13
                port_ff     <= BBRS_PORT_BASE + {10'h000, bb_pipe}
                               + chofs_ff; // RULE_02
            end
        end
    end

    // link drive
    assign link.valid    = out_valid_ff;
    assign link.sop      = out_sop_ff;
    assign link.eop      = out_eop_ff;
    assign link.data     = out_data_ff;
    assign link.ver      = BBRS_RTP_VER;
    assign link.pad      = BBRS_PAD; // RULE_12
    assign link.ext      = ext_ff;
    assign link.cc       = BBRS_CC; // RULE_10
    assign link.marker   = marker_ff;
    assign link.pt       = BBRS_PT; // RULE_11
    assign link.seq      = hseq_ff;
    assign link.ts       = ts_ff;
    assign link.ssrc     = ssrc_ff;
    assign link.ext_word = ext_word_ff;
    assign link.dst_ip   = BBRS_MCAST_IP; // RULE_02
    assign link.dst_port = port_ff;
endmodule

// >>> hw/bbrs_consumer.sv
// segment consumer: checks, reassembles and delivers baseband packets
`timescale 1ns/1ps
module bbrs_consumer
    import bbrs_pkg::*;
#(
    parameter int DEPTH = 8192
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // segment link
    bbrs_link_if.rx          link,
    // rebuilt baseband packet output
    output logic             bb_valid,
    input  wire logic        bb_ready,
    output logic [7:0]       bb_data,
    output logic             bb_last,
    output logic [31:0]      bb_ts,
    output logic             lost
);
    localparam int AW = $clog2(DEPTH);

    bbrs_rx_state_e state_ff;
    logic [7:0]     mem [DEPTH];
    logic [31:0]    cnt_ff;
    logic [31:0]    target_ff;
    logic [31:0]    rd_ff;
    logic [15:0]    exp_seq_ff;
    logic           skip_ff;
    logic           lost_ff;
    logic           bb_valid_ff;
    logic [7:0]     bb_data_ff;
    logic           bb_last_ff;
    logic [31:0]    ts_ff;
    logic           acc;
    logic           hdr_ok;
    logic           start;
    logic           cont_ok;
    logic           keep;
    logic [31:0]    nxt_cnt;
    logic           load;

    assign link.ready = state_ff != RX_PLAY;
    assign acc     = link.valid && link.ready;
    assign hdr_ok  = link.pt == BBRS_PT && link.cc == BBRS_CC;
    assign start   = acc && link.sop && link.marker && hdr_ok;
    // in-order continuation of the running set
    assign cont_ok = state_ff == RX_COLLECT
                     && link.seq == exp_seq_ff && hdr_ok; // RULE_14
    assign keep    = acc && (link.sop ? (start || (!link.marker && cont_ok))
                                      : (!skip_ff && state_ff == RX_COLLECT));
    assign nxt_cnt = start ? 32'h1 : cnt_ff + 32'h1;
    assign load    = state_ff == RX_PLAY && rd_ff < target_ff
                     && (!bb_valid_ff || bb_ready);

    // per-packet skip flag and expected sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_ff    <= 1'b0;
            exp_seq_ff <= 16'h0000;
        end else if (acc && link.sop) begin
            skip_ff    <= !keep;
            exp_seq_ff <= link.seq + 16'h0001;
        end
    end

    // byte store
    always_ff @(posedge pclk) begin
        if (keep && (start ? 32'h0 : cnt_ff) < DEPTH) begin
            mem[start ? '0 : cnt_ff[AW-1:0]] <= link.data;
        end
    end

    // reassembly state and counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= RX_IDLE;
            cnt_ff    <= 32'h0;
            target_ff <= 32'h0;
            ts_ff     <= 32'h0;
            lost_ff   <= 1'b0;
        end else begin
            lost_ff <= 1'b0;
            case (state_ff)
                RX_IDLE, RX_COLLECT: begin
                    if (start) begin
                        // early marker discards the running set
                        lost_ff   <= state_ff == RX_COLLECT; // RULE_08
                        target_ff <= link.ssrc;
                        ts_ff     <= link.ts;
                    end
                    if (acc && link.sop && !keep
                        && state_ff == RX_COLLECT) begin
                        lost_ff  <= 1'b1; // RULE_08
                        state_ff <= RX_IDLE;
                    end else if (keep) begin
                        cnt_ff   <= nxt_cnt; // RULE_07 RULE_16
                        state_ff <= RX_COLLECT;
                        if (nxt_cnt > DEPTH || (!start
                            && nxt_cnt > target_ff)) begin
                            lost_ff  <= 1'b1; // RULE_17
                            state_ff <= RX_IDLE;
                        end else if (link.eop && nxt_cnt ==
                                     (start ? link.ssrc : target_ff)) begin
                            state_ff <= RX_PLAY; // RULE_17
                        end
                    end
                end
                RX_PLAY: begin
                    if (rd_ff >= target_ff && !bb_valid_ff) begin
                        state_ff <= RX_IDLE;
                    end
                end
                default: state_ff <= RX_IDLE;
            endcase
        end
    end

    // playout of the completed packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff       <= 32'h0;
            bb_valid_ff <= 1'b0;
            bb_data_ff  <= 8'h00;
            bb_last_ff  <= 1'b0;
        end else if (state_ff != RX_PLAY) begin
            rd_ff       <= 32'h0;
            bb_valid_ff <= 1'b0;
        end else if (load) begin
            rd_ff       <= rd_ff + 32'h1;
            bb_valid_ff <= 1'b1;
            bb_data_ff  <= mem[rd_ff[AW-1:0]];
            bb_last_ff  <= rd_ff + 32'h1 == target_ff;
        end else if (bb_ready) begin
            bb_valid_ff <= 1'b0;
        end
    end

    assign bb_valid = bb_valid_ff;
    assign bb_data  = bb_data_ff;
    assign bb_last  = bb_last_ff;
    assign bb_ts    = ts_ff;
    assign lost     = lost_ff;
endmodule

// >>> tb/bbrs_chk.sv
// link checker: header fields and set relations on the segment link
`timescale 1ns/1ps
module bbrs_chk
    import bbrs_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // handshake and framing
    input wire logic        valid,
    input wire logic        ready,
    input wire logic        sop,
    // header fields
    input wire logic [1:0]  ver,
    input wire logic        pad,
    input wire logic        ext,
    input wire logic [3:0]  cc,
    input wire logic        marker,
    input wire logic [6:0]  pt,
    input wire logic [15:0] seq,
    input wire logic [31:0] ts,
    input wire logic [31:0] ssrc,
    input wire logic [31:0] ext_word,
    input wire logic [31:0] dst_ip
);
    logic [31:0] len_ff;
    logic [31:0] cnt_ff;
    logic [31:0] ts_ff;
    logic [15:0] seq_ff;
    logic        run_ff;

    // running set: length, bytes, timestamp, sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff  <= 1'b0;
            cnt_ff  <= 32'h0;
        end else if (valid && ready) begin
            cnt_ff <= (sop && marker) ? 32'h1 : cnt_ff + 32'h1;
            if (sop && marker) begin
                run_ff <= 1'b1;
                len_ff <= ssrc;
                ts_ff  <= ts;
            end
            if (sop) begin
                seq_ff <= seq;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pt_fixed_a: assert property (valid |-> pt == BBRS_PT)
        else $error("bad payload type");
    csrc_zero_a: assert property (valid |-> cc == BBRS_CC)
        else $error("bad csrc");
    fixed_hdr_a: assert property (valid |-> ver == 2'h2 && !pad)
        else $error("bad version");
    mcast_ip_a: assert property (valid |-> dst_ip == 32'hEF003330)
        else $error("bad group");
    ssrc_zero_a: assert property (
        valid && sop && !marker |-> ssrc == 32'h0)
        else $error("ssrc not zero");
    set_len_a: assert property (
        valid && sop && marker && run_ff |-> cnt_ff == len_ff)
        else $error("bad set length");
    cont_mark_a: assert property (
        valid && sop && !marker |-> run_ff && cnt_ff < len_ff)
        else $error("stray continuation");
    set_ts_a: assert property (valid && sop && !marker |-> ts == ts_ff)
        else $error("timestamp moved");
    seq_step_a: assert property (
        valid && sop && run_ff |-> seq == seq_ff + 16'h1)
        else $error("sequence skip");
    ext_word_a: assert property (valid && !ext |-> ext_word == 32'h0)
        else $error("stray ext word");
    hold_hdr_a: assert property (
        valid && !ready |=> valid && $stable(seq) && $stable(ts))
        else $error("header moved");

    cover property (valid && ready && sop && marker && run_ff);
    cover property (valid && ready && sop && !marker);
    cover property (valid && !ready ##1 valid && ready);
    cover property (valid && ready && ext);
endmodule

// >>> tb/baseband_rtp_segmenter_tb.sv
// bench: segmenter, consumer and a faulty link driver
`timescale 1ns/1ps
module baseband_rtp_segmenter_tb;
    import bbrs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        irq, bb_valid, bb_ready, bb_last, bb_signed, serr;
    logic        c_valid, c_ready, c_last, c_lost, x_lost;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, bb_len, bb_sec, bb_nsec, c_ts, rd, lts;
    logic [7:0]  bb_data, c_data;
    logic [5:0]  bb_pipe;
    logic [16:0] lport;
    logic [31:0] rng = 32'h873F, rng2 = 32'h873F, ext_m = 32'h0;
    logic [7:0]  exp_q[$];
    logic [31:0] ts_q[$], len_q[$], ots_q[$];
    logic [16:0] port_q[$];
    logic [11:0] ofs[6] = '{BBRS_OFS_CTRL, BBRS_OFS_MAXPAY, BBRS_OFS_CHOFS,
                            BBRS_OFS_EXTHDR, BBRS_OFS_IMASK, 12'h01C};
    logic [31:0] rv[6] = '{32'h3, 32'h5B4, 32'h0, 32'h0, 32'h0, 32'h0};
    int          lens[7] = '{1, 6, 7, 8, 14, 15, 22};
    int          errors, n_checks, n_lost, rem, pcnt, plen, chofs_m;
    int          mp_m = 1460;
    bit          seg_m = 1'b1;

    bbrs_link_if lk (.pclk, .presetn);
    bbrs_link_if lk2 (.pclk, .presetn);
    bbrs_segmenter i_bbrs_segmenter (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
        .bb_valid, .bb_ready, .bb_data, .bb_last, .bb_len, .bb_pipe,
        .bb_sec, .bb_nsec, .bb_signed, .link(lk.seg));
    bbrs_consumer i_bbrs_consumer (.pclk, .presetn, .link(lk.rx),
        .bb_valid(c_valid), .bb_ready(c_ready), .bb_data(c_data),
        .bb_last(c_last), .bb_ts(c_ts), .lost(c_lost));
    bbrs_consumer i_bbrs_consumer2 (.pclk, .presetn, .link(lk2.rx),
        .bb_valid(), .bb_ready(1'b1), .bb_data(), .bb_last(), .bb_ts(),
        .lost(x_lost));
    bbrs_chk i_bbrs_chk (.pclk, .presetn, .valid(lk.valid),
        .ready(lk.ready), .sop(lk.sop), .ver(lk.ver), .pad(lk.pad),
        .ext(lk.ext), .cc(lk.cc), .marker(lk.marker), .pt(lk.pt),
        .seq(lk.seq), .ts(lk.ts), .ssrc(lk.ssrc), .ext_word(lk.ext_word),
        .dst_ip(lk.dst_ip));

    // fixed header of the faulty driver
    assign {lk2.ver, lk2.pad, lk2.ext, lk2.cc, lk2.pt} =
        {BBRS_RTP_VER, BBRS_PAD, 1'b0, BBRS_CC, BBRS_PT};
    assign {lk2.ts, lk2.ext_word} = '0;
    assign {lk2.dst_ip, lk2.dst_port} = {BBRS_MCAST_IP, BBRS_PORT_BASE};

    always #4 pclk = ~pclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one clock of a bounded wait
    task automatic tmo(inout int n);
        @(posedge pclk);
        if (++n > 4000) begin
            errors++;
            end_of_test();
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do tmo(n); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic drain;
        int n = 0;
        while (exp_q.size() != 0) tmo(n);
    endtask

    task automatic send(input int len, input bit sg);
        int n;
        logic [31:0] s, ns;
        if (sg) begin
            drain();
            ext_m = xs(rng);
            apb(BBRS_OFS_EXTHDR, 1'b1, ext_m);
        end
        s = xs(rng ^ ext_m);
        ns = xs(s) % 32'd1000000000;
        rng = ns;
        @(posedge pclk);
        bb_len    <= len;
        bb_pipe   <= s[5:0];
        bb_sec    <= s;
        bb_nsec   <= ns;
        bb_signed <= sg;
        ts_q.push_back({s[21:0], ns[29:20]});
        ots_q.push_back(ts_q[$]);
        len_q.push_back(len);
        port_q.push_back({sg, 16'(30000 + s[5:0] + chofs_m)});
        for (int i = 0; i < len; i++) begin
            rng = xs(rng);
            bb_valid <= 1'b1;
            bb_data  <= rng[7:0];
            bb_last  <= (i == len - 1);
            exp_q.push_back(rng[7:0]);
            n = 0;
            do tmo(n); while (bb_ready !== 1'b1);
        end
        bb_valid <= 1'b0;
    endtask

    // faulty far end: one chosen packet
    task automatic raw(input bit m, input logic [15:0] sq, input int len);
        int n;
        @(posedge pclk);
        lk2.marker <= m;
        lk2.seq    <= sq;
        lk2.ssrc   <= m ? 32'h6 : 32'h0;
        for (int i = 0; i < len; i++) begin
            lk2.valid <= 1'b1;
            lk2.sop   <= (i == 0);
            lk2.eop   <= (i == len - 1);
            lk2.data  <= 8'(i);
            n = 0;
            do tmo(n); while (lk2.ready !== 1'b1);
        end
        lk2.valid <= 1'b0;
        lk2.data  <= ~lk2.data;
    endtask

    // link watcher: headers against model
    always @(posedge pclk) begin
        if (presetn && lk.valid === 1'b1 && lk.ready === 1'b1) begin
            if (lk.sop === 1'b1) begin
                chk("marker", rem == 0, lk.marker);
                if (rem == 0) begin
                    rem = len_q.pop_front();
                    lts = ts_q.pop_front();
                    lport = port_q.pop_front();
                end
                chk("ts", lts, lk.ts);
                chk("port", lport[15:0], lk.dst_port);
                chk("ext", lport[16], lk.ext);
                chk("ext word", lport[16] ? ext_m : 0, lk.ext_word);
                plen = (seg_m && rem > mp_m) ? mp_m : rem;
                pcnt = 0;
            end
            pcnt++;
            rem--;
            if (lk.eop === 1'b1)
                chk("packet bytes", plen, pcnt);
        end
    end

    // output watcher, lost pulses, random stall
    always @(posedge pclk) begin
        if (presetn && c_valid === 1'b1 && c_ready === 1'b1) begin
            chk("byte", exp_q.pop_front(), c_data);
            if (c_last === 1'b1)
                chk("set ts", ots_q.pop_front(), c_ts);
        end
        if (presetn && c_lost !== 1'b0)
            chk("lost", 0, c_lost);
        if (x_lost === 1'b1)
            n_lost++;
        rng2 = xs(rng2);
        c_ready <= rng2[0] | rng2[1];
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        c_ready = 1'b1;
        {psel, penable, pwrite, bb_valid, bb_last, bb_signed} = '0;
        {paddr, pwdata, bb_data, bb_len, bb_pipe, bb_sec, bb_nsec} = '0;
        {lk2.valid, lk2.sop, lk2.eop, lk2.marker, lk2.seq, lk2.ssrc} = '0;
        lk2.data = 8'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ofs[i]) begin
            apb(ofs[i], 1'b0, 32'h0);
            chk("reset value", rv[i], rd);
            chk("slverr", i == 5, serr);
        end
        $display("test registers done");
        send(1500, 1'b0);
        drain();
        $display("test long packet done");
        apb(BBRS_OFS_MAXPAY, 1'b1, 32'h7);
        apb(BBRS_OFS_CHOFS, 1'b1, 32'hFFF0);
        mp_m = 7;
        chofs_m = 32'hFFF0;
        foreach (lens[i])
            send(lens[i], lens[i] % 2 == 1);
        drain();
        apb(BBRS_OFS_MAXPAY, 1'b1, 32'h0);
        mp_m = 1;
        send(3, 1'b0);
        drain();
        apb(BBRS_OFS_CTRL, 1'b1, 32'h1);
        seg_m = 1'b0;
        send(40, 1'b0);
        drain();
        $display("test segmentation done");
        apb(BBRS_OFS_ISTAT, 1'b0, 32'h0);
        chk("istat", 32'h3, rd);
        chk("irq", 0, irq);
        apb(BBRS_OFS_IMASK, 1'b1, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(BBRS_OFS_ISTAT, 1'b1, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq", 0, irq);
        apb(BBRS_OFS_ISTAT, 1'b0, 32'h0);
        chk("istat", 32'h1, rd);
        $display("test interrupts done");
        raw(1'b1, 16'h000A, 3);
        raw(1'b1, 16'h000B, 2);
        raw(1'b0, 16'h000D, 4);
        raw(1'b1, 16'h0014, 4);
        raw(1'b0, 16'h0015, 4);
        raw(1'b1, 16'h001E, 2);
        raw(1'b0, 16'h001F, 4);
        repeat (20) @(posedge pclk);
        chk("lost sets", 3, n_lost);
        $display("test faulty far end done");
        end_of_test();
    end
endmodule
